// [design/sdpi_pkg.sv]
// Shared constants and types for the memory pin interface.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package sdpi_pkg;

	localparam int          CLK_OUTS     = 4;       // Memory clock outputs.
	localparam int          RANKS        = 4;       // Rank selects.
	localparam int          LANES        = 8;       // Byte lanes of the data bus.
	localparam int          LANE_BITS    = 8;       // Data bits per byte lane.
	localparam logic [3:0]  CLK_EN_RST   = 4'h0;    // All clocks parked high in reset.
	localparam logic [3:0]  RANK_N_RST   = 4'hf;    // All ranks deselected.
	localparam logic [7:0]  MASK_RST     = 8'hff;   // All lanes masked.
	localparam logic [7:0]  CB_RST       = 8'h00;   // Captured check bits after reset.
	localparam logic        STROBE_RST   = 1'b1;    // Command strobes inactive.
	localparam logic        CKE_RST      = 1'b1;    // Memory clock enable high.
	localparam logic [1:0]  HOLD_CYCLES  = 2'h1;    // Quiet cycles after reset release.
	localparam logic [1:0]  HOLD_ZERO    = 2'h0;    // Start value of the hold count.
	localparam logic [1:0]  HOLD_STEP    = 2'h1;    // Increment of the hold count.

	// Top-level sequencing: quiet hold after reset, then normal running.
	typedef enum logic [1:0]
	{
		SDPI_ST_HOLD = 2'b01,
		SDPI_ST_RUN  = 2'b10
	} sdpi_state_e;

endpackage : sdpi_pkg

// [design/sdpi_lane.sv]
// One byte lane: data mask output and its check-bit pin.
module sdpi_lane
(
	input  wire logic mclk,        // System bus clock.
	input  wire logic rst,         // Synchronous reset, active high.
	input  wire logic ce,          // Clock enable; state frozen while low.
	input  wire logic run,         // High once the post-reset hold is over.
	input  wire logic cb_sel,      // Pin multiplexer hands the pin to this block.
	input  wire logic mask_req,    // Requested mask for this lane.
	input  wire logic cb_wr_en,    // Drive the check bit this cycle.
	input  wire logic cb_wr,       // Check bit value to drive.
	input  wire logic cap,         // Capture strobe from the feedback path.
	input  wire logic cb_i,        // Check-bit pin level.
	output logic      mask,        // Data mask pin.
	output logic      cb_o,        // Check-bit pin drive value.
	output logic      cb_oe,       // Check-bit pin output enable.
	output logic      rd_cb        // Last captured check bit.
);

	// All lane state in one record.
	typedef struct packed
	{
		logic mask;
		logic cb_o;
		logic cb_oe;
		logic rd_cb;
	} sdpi_lane_s;

	sdpi_lane_s r;       // Registered state.
	sdpi_lane_s next_r;  // Next state.

	//--------------------------------------------------------------------------
	// Next-state logic
	//--------------------------------------------------------------------------
	// Masks stay set and the pin stays an input until running.
	always_comb
	begin
		next_r = r;
		if (!run)
		begin
			next_r.mask  = 1'b1;
			next_r.cb_oe = 1'b0;
		end
		else
		begin
			next_r.mask  = mask_req;
			next_r.cb_oe = cb_sel & cb_wr_en;
			next_r.cb_o  = cb_wr;
		end
		// A foreign function owns the pin unless selected, so ignore it.
		if (cap && cb_sel)
		begin
			next_r.rd_cb = cb_i;
		end
	end

	//--------------------------------------------------------------------------
	// State register
	//--------------------------------------------------------------------------
	// Reset overrides the clock enable so pins are safe at once.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			r.mask  <= 1'b1;
			r.cb_o  <= 1'b0;
			r.cb_oe <= 1'b0;
			r.rd_cb <= 1'b0;
		end
		else if (ce)
		begin
			r <= next_r;
		end
	end

	assign mask  = r.mask;
	assign cb_o  = r.cb_o;
	assign cb_oe = r.cb_oe;
	assign rd_cb = r.rd_cb;

	// The pin is not driven once another function has owned it for two cycles.
	cb_owner_a: assert property (@(posedge mclk) disable iff (rst)
		!cb_sel && !$past(cb_sel) |-> !cb_oe)
		else $error("check bit driven while not selected");

endmodule : sdpi_lane

// [design/sdpi_top.sv]
// Pin-level logic of the memory side: clocks, selects, strobes, masks, check bits.
module sdpi_top
#(
	parameter int CLK_OUTS = sdpi_pkg::CLK_OUTS,  // Number of memory clocks.
	parameter int RANKS    = sdpi_pkg::RANKS,     // Number of rank selects.
	parameter int LANES    = sdpi_pkg::LANES      // Number of byte lanes.
)
(
	input  wire logic                mclk,                 // System bus clock, 20 MHz.
	input  wire logic                rst,                  // Synchronous reset, high.
	input  wire logic                ce,                   // Clock enable.
	input  wire logic [CLK_OUTS-1:0] mem_clk_out_en,       // Clock enable field.
	input  wire logic                feedback_loop_en,     // Internal loopback enable.
	input  wire logic                check_bit_sel,        // Pin multiplexer choice.
	input  wire logic                cmd_valid,            // Issue a command this cycle.
	input  wire logic [RANKS-1:0]    cmd_rank,             // Ranks addressed, high true.
	input  wire logic                cmd_row,              // Assert row strobe.
	input  wire logic                cmd_col,              // Assert column strobe.
	input  wire logic                cmd_write,            // Assert write enable.
	input  wire logic                cke_req,              // Requested memory clock enable.
	input  wire logic [LANES-1:0]    data_mask_req,        // Requested lane masks.
	input  wire logic                cb_wr_en,             // Drive check bits.
	input  wire logic [LANES-1:0]    cb_wr,                // Check bits to drive.
	input  wire logic                rd_sample,            // Read data expected now.
	output logic      [CLK_OUTS-1:0] mem_clk_out,          // Memory clock pins.
	input  wire logic                mem_feedback_clk_i,   // Feedback pin level.
	output logic                     mem_feedback_clk_o,   // Feedback pin drive.
	output logic                     mem_feedback_clk_oe,  // Feedback pin enable.
	output logic      [RANKS-1:0]    rank_select_n,        // Rank selects, low true.
	output logic                     row_strobe_n,         // Row strobe, low true.
	output logic                     col_strobe_n,         // Column strobe, low true.
	output logic                     write_en_n,           // Write enable, low true.
	output logic                     mem_cke,              // Memory clock enable pin.
	output logic      [LANES-1:0]    data_mask,            // Lane mask pins.
	input  wire logic [LANES-1:0]    check_bits_i,         // Check-bit pin levels.
	output logic      [LANES-1:0]    check_bits_o,         // Check-bit drive values.
	output logic      [LANES-1:0]    check_bits_oe,        // Check-bit enables.
	output logic      [LANES-1:0]    rd_check_bits,        // Captured check bits.
	output logic                     rd_cb_valid           // Capture happened, pulse.
);

	//--------------------------------------------------------------------------
	// State record
	//--------------------------------------------------------------------------
	// Every flip-flop of this module lives in this record.
	typedef struct packed
	{
		sdpi_pkg::sdpi_state_e state;    // Hold or run.
		logic [1:0]            hold;     // Cycles spent in hold.
		logic [CLK_OUTS-1:0]   clk_en;   // Registered clock enables.
		logic                  loop_en;  // Registered loopback enable.
		logic                  fb_prev;  // Feedback pin level last cycle.
		logic [RANKS-1:0]      rank_n;   // Rank select pins.
		logic                  row_n;    // Row strobe pin.
		logic                  col_n;    // Column strobe pin.
		logic                  we_n;     // Write enable pin.
		logic                  cke;      // Memory clock enable pin.
		logic                  valid;    // Capture flag towards the controller.
	} sdpi_regs_s;

	sdpi_regs_s r;       // Registered state.
	sdpi_regs_s next_r;  // Next state.

	logic run;           // Running, so pins may leave their idle levels.
	logic fb_edge;       // Rising edge seen on the feedback pin.
	logic cap;           // Capture strobe for read check bits.

	assign run = (r.state == sdpi_pkg::SDPI_ST_RUN);

	//--------------------------------------------------------------------------
	// Feedback path
	//--------------------------------------------------------------------------
	// The pin is taken as synchronous, so its edge is a plain compare.
	assign fb_edge = mem_feedback_clk_i & ~r.fb_prev;

	// With loopback the internal clock samples every cycle; else the pin edge.
	assign cap = run & rd_sample & (r.loop_en | fb_edge);

	//--------------------------------------------------------------------------
	// Next-state logic
	//--------------------------------------------------------------------------
	// Sequencing, command registers and the configuration copies.
	always_comb
	begin
		next_r         = r;
		next_r.clk_en  = mem_clk_out_en;
		next_r.loop_en = feedback_loop_en;
		next_r.fb_prev = mem_feedback_clk_i;
		next_r.valid   = cap & check_bit_sel;
		case (r.state)
			sdpi_pkg::SDPI_ST_HOLD:
			begin
				// Pins stay idle for the hold time after reset release.
				next_r.rank_n = sdpi_pkg::RANK_N_RST;
				next_r.row_n  = sdpi_pkg::STROBE_RST;
				next_r.col_n  = sdpi_pkg::STROBE_RST;
				next_r.we_n   = sdpi_pkg::STROBE_RST;
				next_r.cke    = sdpi_pkg::CKE_RST;
				next_r.hold   = 2'(r.hold + sdpi_pkg::HOLD_STEP);
				if (next_r.hold >= sdpi_pkg::HOLD_CYCLES)
				begin
					next_r.state = sdpi_pkg::SDPI_ST_RUN;
				end
			end
			sdpi_pkg::SDPI_ST_RUN:
			begin
				next_r.cke = cke_req;
				if (cmd_valid)
				begin
					// Selected ranks go low with the strobes asked for.
					next_r.rank_n = ~cmd_rank;
					next_r.row_n  = ~cmd_row;
					next_r.col_n  = ~cmd_col;
					next_r.we_n   = ~cmd_write;
				end
				else
				begin
					// No command: deselect everything, a plain no-operation.
					next_r.rank_n = sdpi_pkg::RANK_N_RST;
					next_r.row_n  = sdpi_pkg::STROBE_RST;
					next_r.col_n  = sdpi_pkg::STROBE_RST;
					next_r.we_n   = sdpi_pkg::STROBE_RST;
				end
			end
			default:
			begin
				// An illegal code returns to the safe hold state.
				next_r.state = sdpi_pkg::SDPI_ST_HOLD;
				next_r.hold  = sdpi_pkg::HOLD_ZERO;
			end
		endcase
	end

	//--------------------------------------------------------------------------
	// State register
	//--------------------------------------------------------------------------
	// Reset wins over the clock enable so the pins idle straight away.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			r.state   <= sdpi_pkg::SDPI_ST_HOLD;
			r.hold    <= sdpi_pkg::HOLD_ZERO;
			r.clk_en  <= sdpi_pkg::CLK_EN_RST;
			r.loop_en <= 1'b0;
			r.fb_prev <= 1'b0;
			r.rank_n  <= sdpi_pkg::RANK_N_RST;
			r.row_n   <= sdpi_pkg::STROBE_RST;
			r.col_n   <= sdpi_pkg::STROBE_RST;
			r.we_n    <= sdpi_pkg::STROBE_RST;
			r.cke     <= sdpi_pkg::CKE_RST;
			r.valid   <= 1'b0;
		end
		else if (ce)
		begin
			r <= next_r;
		end
	end

	//--------------------------------------------------------------------------
	// Clock outputs
	//--------------------------------------------------------------------------
	// Enables change at the rising edge, while the clock is high, so the
	// OR gate cannot glitch. A parked clock simply stays high.
	assign mem_clk_out = {CLK_OUTS{mclk}} | ~r.clk_en | {CLK_OUTS{rst}};

	// Loopback drives the internal clock out on the feedback pin.
	assign mem_feedback_clk_o  = mclk & r.loop_en;
	assign mem_feedback_clk_oe = r.loop_en;

	//--------------------------------------------------------------------------
	// Command outputs
	//--------------------------------------------------------------------------
	assign rank_select_n = r.rank_n;
	assign row_strobe_n  = r.row_n;
	assign col_strobe_n  = r.col_n;
	assign write_en_n    = r.we_n;
	assign mem_cke       = r.cke;
	assign rd_cb_valid   = r.valid;

	//--------------------------------------------------------------------------
	// Byte lanes
	//--------------------------------------------------------------------------
	// Lane n carries mask n and check bit n for data byte n.
	for (genvar n = 0; n < LANES; n++)
	begin : g_lane
		sdpi_lane u_lane
		(
			.mclk     (mclk),
			.rst      (rst),
			.ce       (ce),
			.run      (run),
			.cb_sel   (check_bit_sel),
			.mask_req (data_mask_req[n]),
			.cb_wr_en (cb_wr_en),
			.cb_wr    (cb_wr[n]),
			.cap      (cap),
			.cb_i     (check_bits_i[n]),
			.mask     (data_mask[n]),
			.cb_o     (check_bits_o[n]),
			.cb_oe    (check_bits_oe[n]),
			.rd_cb    (rd_check_bits[n])
		);
	end

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	// A reset cycle followed by its release.
	sequence s_release;
		rst ##1 !rst;
	endsequence

	// A command accepted while running.
	sequence s_cmd;
		ce && run && cmd_valid && !rst;
	endsequence

	// Clocks are high whenever reset is applied.
	clk_reset_high_a: assert property (@(posedge mclk)
		rst |-> (&mem_clk_out))
		else $error("memory clock low during reset");

	// Clock 0, when its enable stays clear for two taken edges, reads high at the second edge and at the next rising edge.
	clk_parked_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && !mem_clk_out_en[0]) [*2] |-> mem_clk_out[0] ##1 mem_clk_out[0])
		else $error("parked memory clock toggled");

	// The feedback pin is an input after reset until loopback is asked for.
	fb_input_a: assert property (@(posedge mclk)
		s_release |-> !mem_feedback_clk_oe)
		else $error("feedback pin driven after reset");

	// Loopback turns the pin around one cycle after it is enabled.
	fb_drive_a: assert property (@(posedge mclk) disable iff (rst)
		ce && feedback_loop_en |=> mem_feedback_clk_oe)
		else $error("feedback pin not driven in loopback");

	// Selects and strobes idle during and just after reset.
	cmd_idle_a: assert property (@(posedge mclk)
		s_release |-> (&rank_select_n) && row_strobe_n && col_strobe_n
			&& write_en_n && mem_cke)
		else $error("command pins active around reset");

	// A command reaches the pins one cycle after it is taken.
	cmd_issue_a: assert property (@(posedge mclk) disable iff (rst)
		s_cmd |=> rank_select_n == ~$past(cmd_rank)
			&& row_strobe_n == !$past(cmd_row) && write_en_n == !$past(cmd_write))
		else $error("command pins do not match request");

	// The memory clock enable is high while held after reset.
	cke_hold_a: assert property (@(posedge mclk)
		rst ##1 (!rst && !run) |-> mem_cke)
		else $error("memory clock enable low after reset");

	// Masks are all set at release and follow requests when running.
	mask_reset_a: assert property (@(posedge mclk)
		s_release |-> (&data_mask))
		else $error("data mask not set after reset");

	mask_follow_a: assert property (@(posedge mclk) disable iff (rst)
		ce && run |=> data_mask == $past(data_mask_req))
		else $error("data mask does not follow request");

	// Check bits are inputs after reset.
	cb_input_a: assert property (@(posedge mclk)
		s_release |-> check_bits_oe == '0)
		else $error("check bits driven after reset");

	// A selected loopback read always produces a capture one cycle later.
	cap_loop_a: assert property (@(posedge mclk) disable iff (rst)
		ce && run && r.loop_en && rd_sample && check_bit_sel |=> rd_cb_valid)
		else $error("loopback read not captured");

endmodule : sdpi_top

// [test/sdpi_mem_model.sv]
// Behavioural model of the memory devices and board on the far side of the pins.
module sdpi_mem_model
(
	input  wire logic       mclk,                // System bus clock.
	input  wire logic       drive_en,            // Memories drive read check bits.
	input  wire logic [7:0] drive_val,           // Check bits that the memories return.
	input  wire logic       fb_run,              // Returned clock runs only within a read.
	input  wire logic [7:0] check_bits_o,        // Controller check-bit drive values.
	input  wire logic [7:0] check_bits_oe,       // Controller check-bit enables.
	input  wire logic       mem_feedback_clk_o,  // Controller feedback pin drive.
	input  wire logic       mem_feedback_clk_oe, // Controller feedback pin enable.
	output logic      [7:0] check_bits_i,        // Resolved check-bit wire levels.
	output logic            mem_feedback_clk_i   // Resolved feedback wire level.
);
	timeunit 1ns;
	timeprecision 1ns;

	logic fb_clk; // Clock returned over the board trace.

	//--------------------------------------------------------------
	// Returned clock
	//--------------------------------------------------------------
	// It toggles off the sampling edge and stands low outside a read.
	initial fb_clk = 1'b0;
	always @(negedge mclk)
	begin
		fb_clk <= fb_run ? ~fb_clk : 1'b0;
	end

	//--------------------------------------------------------------
	// Wire resolution
	//--------------------------------------------------------------
	// Check-bit lines carry a pull-up, so a released line reads high.
	always_comb
	begin
		for (int n = 0; n < 8; n++)
		begin
			if (check_bits_oe[n])
				check_bits_i[n] = check_bits_o[n];
			else if (drive_en)
				check_bits_i[n] = drive_val[n];
			else
				check_bits_i[n] = 1'b1;
		end
		// The controller wins the feedback pin once it drives it.
		mem_feedback_clk_i = mem_feedback_clk_oe ? mem_feedback_clk_o : fb_clk;
	end
endmodule : sdpi_mem_model

// [test/sdram_pin_interface_tb.sv]
// Self-checking bench for the memory pin interface.
module sdram_pin_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk, rst, ce, loop_en, sel, cmd_valid, row, col, wr, cke_req;
	logic cb_wr_en, rd_sample, fb_o, fb_oe, fb_i, row_n, col_n, we_n, cke, cb_valid;
	logic [3:0] clk_en, rank, clk_out, rank_n;
	logic [7:0] mask_req, cb_wr, mask, cb_i, cb_o, cb_oe, rd_cb, mem_val;
	logic       mem_drv, fb_run;
	int         err_count, checks_done, cycles;

	//--------------------------------------------------------------
	// Design, far side and clock
	//--------------------------------------------------------------
	sdpi_top dut (.mclk(mclk), .rst(rst), .ce(ce), .mem_clk_out_en(clk_en),
		.feedback_loop_en(loop_en), .check_bit_sel(sel), .cmd_valid(cmd_valid),
		.cmd_rank(rank), .cmd_row(row), .cmd_col(col), .cmd_write(wr),
		.cke_req(cke_req), .data_mask_req(mask_req), .cb_wr_en(cb_wr_en), .cb_wr(cb_wr),
		.rd_sample(rd_sample), .mem_clk_out(clk_out), .mem_feedback_clk_i(fb_i),
		.mem_feedback_clk_o(fb_o), .mem_feedback_clk_oe(fb_oe), .rank_select_n(rank_n),
		.row_strobe_n(row_n), .col_strobe_n(col_n), .write_en_n(we_n), .mem_cke(cke),
		.data_mask(mask), .check_bits_i(cb_i), .check_bits_o(cb_o),
		.check_bits_oe(cb_oe), .rd_check_bits(rd_cb), .rd_cb_valid(cb_valid));

	sdpi_mem_model mem (.mclk(mclk), .drive_en(mem_drv), .drive_val(mem_val),
		.fb_run(fb_run), .check_bits_o(cb_o), .check_bits_oe(cb_oe),
		.mem_feedback_clk_o(fb_o), .mem_feedback_clk_oe(fb_oe),
		.check_bits_i(cb_i), .mem_feedback_clk_i(fb_i));

	// The clock runs at 20 MHz.
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// A hang is cut short well after the tests should have ended.
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			err_count++;
			print_verdict();
		end
	end

	//--------------------------------------------------------------
	// Compare and closing tasks
	//--------------------------------------------------------------
	task automatic check_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_vec

	task automatic check_flag(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : check_flag

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// Checks every pin of the idle command group.
	task automatic check_idle(input string what);
		check_vec({4'h0, rank_n}, 8'h0f, what);
		check_vec({5'h0, row_n, col_n, we_n}, 8'h07, what);
		check_flag(cke, 1'b1, what);
		check_vec(mask, 8'hff, what);
	endtask : check_idle

	//--------------------------------------------------------------
	// Scenarios
	//--------------------------------------------------------------
	// Reset holds everything idle, and the hold cycle ignores a command.
	task automatic reset_test();
		repeat (4) @(negedge mclk);
		check_idle("reset idle");
		check_vec({4'h0, clk_out}, 8'h0f, "clocks in reset");
		check_vec(cb_oe, 8'h00, "check bits in reset");
		check_flag(fb_oe, 1'b0, "feedback pin in reset");
		check_vec(rd_cb, 8'h00, "captured bits in reset");
		check_flag(cb_valid, 1'b0, "capture flag in reset");
		rst = 1'b0;
		cmd_valid = 1'b1;
		rank = 4'hf;
		row = 1'b1;
		cke_req = 1'b0;
		mask_req = 8'h00;
		@(negedge mclk);
		check_idle("hold cycle");
		cmd_valid = 1'b0;
		cke_req = 1'b1;
		mask_req = 8'hff;
		@(negedge mclk);
		check_idle("after hold");
	endtask : reset_test

	// Each clock enable bit parks its own clock high.
	task automatic clock_test();
		for (int n = 0; n < 5; n++)
		begin
			// The enable changes at a falling edge and is taken at the next rising one.
			@(negedge mclk);
			clk_en = (n == 4) ? 4'hf : ~(4'h1 << n);
			@(negedge mclk);
			#5;
			check_vec({4'h0, clk_out}, {4'h0, ~clk_en}, "clock low phase");
			@(posedge mclk);
			#5;
			check_vec({4'h0, clk_out}, 8'h0f, "clock high phase");
		end
	endtask : clock_test

	// Every strobe combination and a walking rank select, then a NOP.
	task automatic command_test();
		for (int n = 0; n < 8; n++)
		begin
			@(negedge mclk);
			cmd_valid = 1'b1;
			{row, col, wr} = n[2:0];
			rank = 4'h1 << n[1:0];
			@(negedge mclk);
			check_vec({4'h0, rank_n}, {4'h0, ~rank}, "rank select");
			check_vec({5'h0, row_n, col_n, we_n}, {5'h0, ~n[2:0]}, "strobes");
		end
		// A low clock enable freezes the last command on the pins.
		ce = 1'b0;
		cmd_valid = 1'b0;
		@(negedge mclk);
		check_vec({4'h0, rank_n}, {4'h0, ~rank}, "frozen rank select");
		ce = 1'b1;
		@(negedge mclk);
		check_idle("nop");
	endtask : command_test

	// Masks follow their lane one to one, and the clock enable pin follows.
	task automatic mask_test();
		for (int n = 0; n < 8; n++)
		begin
			mask_req = ~(8'h01 << n);
			cke_req = n[0];
			@(negedge mclk);
			@(negedge mclk);
			check_vec(mask, ~(8'h01 << n), "lane mask");
			check_flag(cke, n[0], "clock enable pin");
		end
		mask_req = 8'hff;
		cke_req = 1'b1;
	endtask : mask_test

	// Check bits are driven only while the pin multiplexer selects them.
	task automatic drive_test();
		cb_wr_en = 1'b1;
		cb_wr = 8'haa;
		sel = 1'b1;
		@(negedge mclk);
		@(negedge mclk);
		check_vec(cb_oe, 8'hff, "check bit enable");
		check_vec(cb_o, 8'haa, "check bit value");
		sel = 1'b0;
		@(negedge mclk);
		@(negedge mclk);
		check_vec(cb_oe, 8'h00, "unselected enable");
		cb_wr_en = 1'b0;
	endtask : drive_test

	// A read capture through the loopback, then one refused while unselected.
	task automatic loop_capture_test();
		loop_en = 1'b1;
		@(negedge mclk);
		@(negedge mclk);
		check_flag(fb_oe, 1'b1, "feedback pin driven");
		check_flag(fb_o, 1'b0, "loopback clock low");
		@(posedge mclk);
		#5;
		check_flag(fb_o, 1'b1, "loopback clock high");
		@(negedge mclk);
		mem_drv = 1'b1;
		mem_val = 8'h5a;
		sel = 1'b1;
		rd_sample = 1'b1;
		@(negedge mclk);
		rd_sample = 1'b0;
		check_flag(cb_valid, 1'b1, "loop capture valid");
		check_vec(rd_cb, 8'h5a, "loop capture data");
		@(negedge mclk);
		check_flag(cb_valid, 1'b0, "valid is a pulse");
		sel = 1'b0;
		mem_val = 8'h33;
		rd_sample = 1'b1;
		@(negedge mclk);
		rd_sample = 1'b0;
		check_flag(cb_valid, 1'b0, "unselected capture");
		check_vec(rd_cb, 8'h5a, "unselected data kept");
	endtask : loop_capture_test

	// A read capture timed by the clock returned on the feedback pin.
	task automatic pin_capture_test();
		logic seen;
		seen = 1'b0;
		loop_en = 1'b0;
		sel = 1'b1;
		mem_val = 8'hc3;
		@(negedge mclk);
		@(negedge mclk);
		check_flag(fb_oe, 1'b0, "feedback pin released");
		fb_run = 1'b1;
		rd_sample = 1'b1;
		for (int n = 0; n < 6 && !seen; n++)
		begin
			@(negedge mclk);
			seen = (cb_valid === 1'b1);
		end
		rd_sample = 1'b0;
		fb_run = 1'b0;
		mem_drv = 1'b0;
		check_flag(seen, 1'b1, "pin capture valid");
		check_vec(rd_cb, 8'hc3, "pin capture data");
	endtask : pin_capture_test

	//--------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------
	initial
	begin
		err_count = 0;
		checks_done = 0;
		cycles = 0;
		{rst, ce, clk_en} = {1'b1, 1'b1, 4'hf};
		{loop_en, sel, cmd_valid, row, col, wr, cke_req} = 7'h01;
		{cb_wr_en, rd_sample, mem_drv, fb_run} = 4'h0;
		{rank, mask_req, cb_wr, mem_val} = {4'h0, 8'hff, 8'h00, 8'h00};
		reset_test();
		clock_test();
		command_test();
		mask_test();
		drive_test();
		loop_capture_test();
		pin_capture_test();
		print_verdict();
	end
endmodule : sdram_pin_interface_tb
